// >>> include/csr_params.svh
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_IDX_DATA_LO 8'ha0
`define CSR_IDX_DATA_HI 8'ha1
`define CSR_IDX_CTRL 8'ha2
`define CSR_IDX_START 8'ha3
`define CSR_IDX_IRQ_STS 8'ha4
`define CSR_IDX_IRQ_CLR 8'ha5
`define CSR_IDX_IRQ_EN 8'ha6
`define CSR_IDX_PIN_MODE 8'ha7

`define CSR_SEL_SYS 2'h0
`define CSR_SEL_HALF 2'h1
`define CSR_SEL_TMR 2'h2
`define CSR_SEL_EXT 2'h3

`define CSR_CTL_ORDER 2
`define CSR_CTL_RSVD_VAL 1'b1
`define CSR_START_BIT 0
`define CSR_IRQ_DONE_BIT 0
`define CSR_PM_SIN 0
`define CSR_PM_SERIAL_OUT_PIN 1
`define CSR_PM_SCLK 2

`define CSR_LAST_BIT 4'h7
`define CSR_NIB_RST 4'h0
`define CSR_SEL_RST 2'h0
`define CSR_PM_RST 3'h0
`define CSR_SCLK_IDLE 1'b1
`define CSR_SERIAL_OUT_PIN_RST 1'b0

`endif

// >>> include/csr_pkg.sv
package csr_pkg;

    typedef logic [31:0] csr_word_t;
    typedef logic [3:0] csr_nib_t;

    typedef struct packed {
        logic [7:0] sdata;
        logic [1:0] sel;
        logic order;
        logic start;
        logic [2:0] pmode;
        logic ien;
        logic ists;
        logic [3:0] cnt;
        logic sclk;
        logic serial_out_pin;
        logic prev;
        logic ack;
        csr_nib_t rdata;
    } csr_state_s;

endpackage

// >>> hw/csr_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module csr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule // csr_sync

// >>> hw/csr_tick.sv
`timescale 1ns/1ps
`include "csr_params.svh"
// master shift clock source tick: while start is set, each tick toggles the shift clock unless the start register is written
module csr_tick (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    input wire logic timer1_ovf,
    output logic tick
);
    logic div_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= ~div_reg;
        end
    end

    always_comb begin
        case (sel)
            `CSR_SEL_SYS: tick = 1'b1;
            `CSR_SEL_HALF: tick = div_reg;
            `CSR_SEL_TMR: tick = timer1_ovf;
            default: tick = 1'b0;
        endcase
    end
endmodule // csr_tick

// >>> hw/csr_top.sv
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "csr_params.svh"
module csr_top #(
    parameter int ADDR_W = 10
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire csr_pkg::csr_word_t writedata,
    output csr_pkg::csr_word_t readdata,
    output logic waitrequest,
    input wire logic timer1_ovf,
    input wire logic serial_in_pin_i,
    input wire logic sclk_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    output logic sclk_o,
    output logic sclk_oe,
    output logic irq
);
    import csr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_pipe_reg;
    logic rst_n;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and clock source

    logic sin_sync;
    logic sclk_sync;
    logic tick;
    csr_state_s st_reg;
    csr_state_s st_next;

    csr_sync #(.RST_VAL(1'b0)) u_sin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din(serial_in_pin_i),
        .dout(sin_sync)
    );

    csr_sync #(.RST_VAL(`CSR_SCLK_IDLE)) u_sclk_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din(sclk_i),
        .dout(sclk_sync)
    );

    csr_tick u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .sel(st_reg.sel),
        .timer1_ovf(timer1_ovf),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic out_bit(input logic [7:0] d, input logic lsb_first);
        out_bit = lsb_first ? d[0] : d[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic lsb_first,
                                            input logic b);
        shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    function automatic csr_nib_t rd_nib(input logic [7:0] idx, input csr_state_s s);
        case (idx)
            `CSR_IDX_DATA_LO: rd_nib = s.sdata[3:0];
            `CSR_IDX_DATA_HI: rd_nib = s.sdata[7:4];
            `CSR_IDX_CTRL: rd_nib = {`CSR_CTL_RSVD_VAL, s.order, s.sel};
            `CSR_IDX_START: rd_nib = {3'h0, s.start};
            `CSR_IDX_IRQ_STS: rd_nib = {3'h0, s.ists};
            `CSR_IDX_IRQ_EN: rd_nib = {3'h0, s.ien};
            `CSR_IDX_PIN_MODE: rd_nib = {1'b0, s.pmode};
            default: rd_nib = 4'h0;
        endcase
    endfunction

    localparam csr_state_s ST_RST = '{
        sdata: {`CSR_NIB_RST, `CSR_NIB_RST},
        sel: `CSR_SEL_RST,
        order: 1'b0,
        start: 1'b0,
        pmode: `CSR_PM_RST,
        ien: 1'b0,
        ists: 1'b0,
        cnt: 4'h0,
        sclk: `CSR_SCLK_IDLE,
        serial_out_pin: `CSR_SERIAL_OUT_PIN_RST,
        prev: `CSR_SCLK_IDLE,
        ack: 1'b0,
        rdata: 4'h0
    };

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic req;
    logic take_wr;
    logic [7:0] idx;
    logic master;
    logic sclk_in;
    logic sin_in;
    logic fall_ev;
    logic rise_ev;
    logic done;

    assign req = read | write;
    assign take_wr = write & st_reg.ack;
    assign idx = address[9:2];
    assign master = (st_reg.sel != `CSR_SEL_EXT);
    assign sclk_in = st_reg.pmode[`CSR_PM_SCLK] ? sclk_sync : `CSR_SCLK_IDLE;
    assign sin_in = st_reg.pmode[`CSR_PM_SIN] & sin_sync;

    always_comb begin
        st_next = st_reg;
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        done = 1'b0;
        st_next.ack = req & ~st_reg.ack;
        if (req & ~st_reg.ack & read) begin
            st_next.rdata = rd_nib(idx, st_reg);
        end
        st_next.prev = sclk_in;
        if (master) begin
            fall_ev = st_reg.start & tick & st_reg.sclk;
            rise_ev = st_reg.start & tick & ~st_reg.sclk;
            st_next.sclk = st_reg.start & tick ? ~st_reg.sclk : st_reg.sclk;
        end else begin
            fall_ev = st_reg.start & st_reg.prev & ~sclk_in;
            rise_ev = st_reg.start & ~st_reg.prev & sclk_in;
            st_next.sclk = `CSR_SCLK_IDLE;
        end
        if (fall_ev) begin
            st_next.serial_out_pin = out_bit(st_reg.sdata, st_reg.order);
        end
        if (rise_ev) begin
            st_next.sdata = shift_in(st_reg.sdata, st_reg.order, sin_in);
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `CSR_LAST_BIT) begin
                done = 1'b1;
                st_next.cnt = 4'h0;
                st_next.start = 1'b0;
            end
        end
        if (take_wr) begin
            case (idx)
                `CSR_IDX_DATA_LO: st_next.sdata[3:0] = writedata[3:0];
                `CSR_IDX_DATA_HI: st_next.sdata[7:4] = writedata[3:0];
                `CSR_IDX_CTRL: begin
                    st_next.sel = writedata[1:0];
                    st_next.order = writedata[`CSR_CTL_ORDER];
                end
                `CSR_IDX_START: begin
                    st_next.start = writedata[`CSR_START_BIT];
                    st_next.cnt = 4'h0;
                    st_next.sclk = `CSR_SCLK_IDLE;
                end
                `CSR_IDX_IRQ_EN: st_next.ien = writedata[`CSR_IRQ_DONE_BIT];
                `CSR_IDX_PIN_MODE: st_next.pmode = writedata[2:0];
                default: begin
                end
            endcase
        end
        if (take_wr && idx == `CSR_IDX_IRQ_CLR && writedata[`CSR_IRQ_DONE_BIT]) begin
            st_next.ists = 1'b0;
        end
        if (done) begin
            st_next.ists = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign waitrequest = req & ~st_reg.ack;
    assign readdata = {28'h0, st_reg.rdata};
    assign sclk_o = st_reg.sclk;
    assign sclk_oe = st_reg.pmode[`CSR_PM_SCLK] & master;
    assign serial_out_pin_o = st_reg.serial_out_pin;
    assign serial_out_pin_oe = st_reg.pmode[`CSR_PM_SERIAL_OUT_PIN];
    assign irq = st_reg.ists & st_reg.ien;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_last_rise;
        rise_ev && st_reg.cnt == `CSR_LAST_BIT;
    endsequence

    sequence s_start_write;
        take_wr && idx == `CSR_IDX_START && writedata[`CSR_START_BIT];
    endsequence

    property p_done_irq;
        s_last_rise |=> st_reg.ists;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("byte done did not set interrupt status");

    property p_start_clears;
        (s_last_rise and !(take_wr && idx == `CSR_IDX_START)) |=> !st_reg.start;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start bit not cleared at end of byte");

    property p_start_sets;
        s_start_write |=> st_reg.start && st_reg.cnt == 4'h0;
    endproperty
    a_start_sets: assert property (p_start_sets)
        else $error("start write did not begin a transfer");

    property p_count_bound;
        st_reg.cnt <= `CSR_LAST_BIT;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("bit counter passed eight");

    property p_idle_ignores;
        !st_reg.start |-> !rise_ev && !fall_ev;
    endproperty
    a_idle_ignores: assert property (p_idle_ignores)
        else $error("clock acted on outside a transfer");

    property p_serial_out_pin_on_fall;
        $changed(st_reg.serial_out_pin) |-> $past(fall_ev);
    endproperty
    a_serial_out_pin_on_fall: assert property (p_serial_out_pin_on_fall)
        else $error("data out changed off a falling edge");

    property p_msb_first;
        fall_ev && !st_reg.order |=> st_reg.serial_out_pin == $past(st_reg.sdata[7]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("msb first order broken");

    property p_lsb_first;
        fall_ev && st_reg.order |=> st_reg.serial_out_pin == $past(st_reg.sdata[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("lsb first order broken");

    property p_master_toggle;
        st_reg.start && master && tick && !take_wr |=> st_reg.sclk != $past(st_reg.sclk);
    endproperty
    a_master_toggle: assert property (p_master_toggle)
        else $error("master shift clock missed a tick");

    property p_slave_no_drive;
        st_reg.sel == `CSR_SEL_EXT |-> !sclk_oe;
    endproperty
    a_slave_no_drive: assert property (p_slave_no_drive)
        else $error("slave drove the shift clock");

    property p_pin_gate;
        !st_reg.pmode[`CSR_PM_SERIAL_OUT_PIN] |-> !serial_out_pin_oe;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("data out driven without secondary mode");

    property p_rsvd_read;
        read && !st_reg.ack && idx == `CSR_IDX_CTRL |=> readdata[3] && !waitrequest;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("control bit 3 did not read one");

    property p_lo_read;
        read && !st_reg.ack && idx == `CSR_IDX_DATA_LO
            |=> readdata[3:0] == $past(st_reg.sdata[3:0]);
    endproperty
    a_lo_read: assert property (p_lo_read)
        else $error("low nibble read wrong");

    property p_byte_shift;
        rise_ev && !take_wr |=> st_reg.sdata == shift_in($past(st_reg.sdata),
                                                         $past(st_reg.order), $past(sin_in));
    endproperty
    a_byte_shift: assert property (p_byte_shift)
        else $error("receive shift wrong");

endmodule // csr_top

// >>> verif/csr_peer.sv
`timescale 1ns/1ps
// external clock-synchronous device on the far side of the pins
module csr_peer (
    input wire logic clock,
    input wire logic sclk_line,
    input wire logic dout_line,
    output logic din,
    output logic ext_sclk
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic lsb = 1'b0;
    logic act = 1'b0;
    int nf = 0;
    int nr = 0;
    realtime tf = 0;
    realtime per = 0;
    initial din = 1'b0;
    initial ext_sclk = 1'b1;
    ////////////////////////////////////////
    // load the byte to send and the order
    task automatic arm(input logic [7:0] b, input logic l);
        tx = b;
        lsb = l;
        nf = 0;
        nr = 0;
        act = 1'b1;
    endtask
    // slave-mode clock bursts, idle high
    task automatic clocks(input int n);
        #5;
        repeat (n) begin
            ext_sclk = 1'b0;
            #80;
            ext_sclk = 1'b1;
            #80;
        end
    endtask
    ////////////////////////////////////////
    // change data on falling edge, only the first eight
    always @(negedge sclk_line) begin
        per = $realtime - tf;
        tf = $realtime;
        if (act && nf < 8) begin
            din <= lsb ? tx[nf] : tx[7 - nf];
            nf++;
        end
    end
    // take data on rising edge
    always @(posedge sclk_line) begin
        if (act && nr < 8) begin
            rx <= lsb ? {dout_line, rx[7:1]} : {rx[6:0], dout_line};
            nr++;
        end
    end
    // line not held: changes every cycle
    always @(posedge clock) begin
        if (!act || nr >= 8) begin
            din <= ~din;
        end
    end
endmodule // csr_peer

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
    import csr_pkg::*;
    logic clock = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, timer1_ovf = 1'b0;
    logic [9:0] address = 10'h000;
    csr_word_t writedata = 32'h0, readdata, q;
    logic waitrequest, din, sclk_o, sclk_oe, dout, doe, irq, ext_sclk, lsb, ien;
    logic [1:0] sel;
    logic [7:0] tx, ptx;
    logic [2:0] tdiv = 3'h0;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    wire logic sclk_line = sclk_oe ? sclk_o : ext_sclk;
    wire logic dout_line = doe ? dout : 1'b1;
    csr_top dut_u (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .timer1_ovf(timer1_ovf), .serial_in_pin_i(din), .sclk_i(sclk_line),
        .serial_out_pin_o(dout), .serial_out_pin_oe(doe), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
        .irq(irq));
    csr_peer peer_u (.clock(clock), .sclk_line(sclk_line), .dout_line(dout_line), .din(din),
        .ext_sclk(ext_sclk));
    ////////////////////////////////////////
    always #4 clock = ~clock;
    always @(posedge clock) begin
        tdiv <= tdiv + 3'h1;
        timer1_ovf <= (tdiv == 3'h7);
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input csr_word_t d);
        address <= {idx, 2'h0};
        read <= !wr;
        write <= wr;
        writedata <= d;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic chk_reg(input csr_word_t got, input csr_word_t exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    function automatic csr_word_t exp_per(input logic [1:0] s);
        case (s)
            2'h0: return 32'h10;
            2'h1: return 32'h20;
            2'h2: return 32'h80;
            default: return 32'ha0;
        endcase
    endfunction
    function automatic logic last_bit(input logic [7:0] b, input logic l);
        return l ? b[7] : b[0];
    endfunction
    task automatic end_of_test;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(52603));
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk_pin(sclk_o, 1'b1);
        chk_pin(dout, 1'b0);
        chk_pin(sclk_oe, 1'b0);
        chk_pin(doe, 1'b0);
        for (int i = 0; i < 8; i++) begin
            if (i != 5) begin
                bus(1'b0, 8'ha0 + 8'(i), 32'h0);
                chk_reg(q, (i == 2) ? 32'h8 : 32'h0);
            end
        end
        bus(1'b1, 8'hb0, 32'hf);
        bus(1'b0, 8'hb0, 32'h0);
        chk_reg(q, 32'h0);
        bus(1'b1, 8'ha7, 32'h7);
        chk_pin(doe, 1'b1);
        bus(1'b1, 8'ha6, 32'h1);
        for (int i = 0; i < 12; i++) begin
            sel = 2'(i);
            lsb = (i < 8) ? 1'(i >> 2) : 1'($urandom);
            tx = (i == 0) ? 8'h01 : 8'($urandom);
            ptx = (i == 0) ? 8'h80 : 8'($urandom);
            ien = (i != 10);
            if (!ien) begin
                bus(1'b1, 8'ha6, 32'h0);
            end
            bus(1'b1, 8'ha2, {29'h0, lsb, sel});
            bus(1'b0, 8'ha2, 32'h0);
            chk_reg(q, {28'h0, 1'b1, lsb, sel});
            bus(1'b1, 8'ha0, {28'h0, tx[3:0]});
            bus(1'b1, 8'ha1, {28'h0, tx[7:4]});
            peer_u.arm(ptx, lsb);
            chk_pin(sclk_oe, sel != 2'h3);
            bus(1'b1, 8'ha3, 32'h1);
            if (sel == 2'h3) begin
                peer_u.clocks(10);
            end
            q = 32'h1;
            for (int j = 0; j < 200 && q[0] !== 1'b0; j++) begin
                bus(1'b0, 8'ha3, 32'h0);
            end
            chk_reg(q, 32'h0);
            repeat (2) @(posedge clock);
            chk_pin(irq, ien);
            bus(1'b0, 8'ha4, 32'h0);
            chk_reg(q, 32'h1);
            chk_reg(32'(int'(peer_u.per)), exp_per(sel));
            chk_pin(sclk_o, 1'b1);
            chk_pin(dout, last_bit(tx, lsb));
            if (sel != 2'h0) begin
                chk_reg({24'h0, peer_u.rx}, {24'h0, tx});
            end
            if (sel[1]) begin
                bus(1'b0, 8'ha0, 32'h0);
                chk_reg(q, {28'h0, ptx[3:0]});
                bus(1'b0, 8'ha1, 32'h0);
                chk_reg(q, {28'h0, ptx[7:4]});
            end
            bus(1'b1, 8'ha6, 32'h1);
            chk_pin(irq, 1'b1);
            bus(1'b1, 8'ha5, 32'h1);
            chk_pin(irq, 1'b0);
        end
        end_of_test();
    end
endmodule // tb
